// file: system_tick_timer.v
// Purpose: 24-bit decrementing system tick timer with reload and wrap flag.
// Assumes: Register port is synchronous to clk; reads answer one cycle later.
// Notes: Interrupt status bit is write-one-to-clear; the set wins over a clear.
`include "tick_timer_regs.vh"

module system_tick_timer (
  // Clock, reset and clock enable
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Interrupt
  output wire irq
);

  // --------------------------------------------------------------------------
  // State and next values
  // --------------------------------------------------------------------------
  reg enable;
  reg next_enable;
  reg [`COUNT_WIDTH-1:0] reload_value;
  reg [`COUNT_WIDTH-1:0] next_reload_value;
  reg [`COUNT_WIDTH-1:0] current_count_value;
  reg [`COUNT_WIDTH-1:0] next_count;
  reg wrap_flag;
  reg next_wrap_flag;
  reg irq_status;
  reg next_irq_status;
  reg irq_mask;
  reg next_irq_mask;
  reg [31:0] next_rdata;
  reg wrap_event;
  reg count_is_zero;
  reg count_is_one;

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  // Address match, shared by the write and the read decoders.
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Count comparison, shared by the zero and the one detectors.
  function count_equals;
    input [`COUNT_WIDTH-1:0] value;
    input [`COUNT_WIDTH-1:0] target;
    begin
      count_equals = (value == target);
    end
  endfunction

  wire wr_control = wr && hit(addr, `OFS_CONTROL);
  wire wr_reload = wr && hit(addr, `OFS_RELOAD);
  wire wr_current = wr && hit(addr, `OFS_CURRENT);
  wire wr_status = wr && hit(addr, `OFS_IRQ_STATUS);
  wire wr_mask = wr && hit(addr, `OFS_IRQ_MASK);
  wire rd_control = rd && hit(addr, `OFS_CONTROL);
  wire rd_reload = rd && hit(addr, `OFS_RELOAD);
  wire rd_current = rd && hit(addr, `OFS_CURRENT);
  wire rd_status = rd && hit(addr, `OFS_IRQ_STATUS);
  wire rd_mask = rd && hit(addr, `OFS_IRQ_MASK);

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  always @*
  begin
    count_is_zero = count_equals(current_count_value, {`COUNT_WIDTH{1'b0}});
    count_is_one = count_equals(current_count_value, {{(`COUNT_WIDTH-1){1'b0}}, 1'b1});
  end

  // A write to the current count overrides only the count, never the wrap event.
  always @*
  begin
    next_count = current_count_value;
    wrap_event = 1'b0;
    if (enable && count_is_one)
    begin
      wrap_event = 1'b1;
    end
    if (wr_current)
    begin
      next_count = {`COUNT_WIDTH{1'b0}};
    end
    else if (enable)
    begin
      if (count_is_zero)
      begin
        next_count = reload_value;
      end
      else
      begin
        next_count = current_count_value - {{(`COUNT_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // The counter has no reset: its power-up content is undefined.
  always @(posedge clk)
  begin
    if (clk_en)
    begin
      current_count_value <= next_count;
    end
  end

  // --------------------------------------------------------------------------
  // Control
  // --------------------------------------------------------------------------
  always @*
  begin
    next_enable = enable;
    if (wr_control)
    begin
      next_enable = wdata[`CTRL_ENABLE_BIT];
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      enable <= 1'b0;
    end
    else if (clk_en)
    begin
      enable <= next_enable;
    end
  end

  // --------------------------------------------------------------------------
  // Reload value
  // --------------------------------------------------------------------------
  always @*
  begin
    next_reload_value = reload_value;
    if (wr_reload)
    begin
      next_reload_value = wdata[`COUNT_WIDTH-1:0];
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reload_value <= `RELOAD_RESET;
    end
    else if (clk_en)
    begin
      reload_value <= next_reload_value;
    end
  end

  // --------------------------------------------------------------------------
  // Wrap flag
  // --------------------------------------------------------------------------
  // A wrap in the same cycle as a read keeps the flag set, so no wrap is lost.
  always @*
  begin
    next_wrap_flag = wrap_flag;
    if (wrap_event)
    begin
      next_wrap_flag = 1'b1;
    end
    else if (rd_control)
    begin
      next_wrap_flag = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrap_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      wrap_flag <= next_wrap_flag;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  // The set wins over a write-one-to-clear in the same cycle.
  always @*
  begin
    next_irq_status = irq_status;
    if (wrap_event)
    begin
      next_irq_status = 1'b1;
    end
    else if (wr_status && wdata[`IRQ_WRAP_BIT])
    begin
      next_irq_status = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_status <= next_irq_status;
    end
  end

  always @*
  begin
    next_irq_mask = irq_mask;
    if (wr_mask)
    begin
      next_irq_mask = wdata[`IRQ_WRAP_BIT];
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_mask <= `MASK_RESET;
    end
    else if (clk_en)
    begin
      irq_mask <= next_irq_mask;
    end
  end

  assign irq = irq_status & irq_mask;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Unmapped reads and idle cycles give zero, so the data stand for one cycle only.
  always @*
  begin
    next_rdata = 32'h00000000;
    if (rd_control)
    begin
      next_rdata[`CTRL_ENABLE_BIT] = enable;
      next_rdata[`CTRL_WRAP_FLAG_BIT] = wrap_flag;
    end
    if (rd_reload)
    begin
      next_rdata[`COUNT_WIDTH-1:0] = reload_value;
    end
    if (rd_current)
    begin
      next_rdata[`COUNT_WIDTH-1:0] = current_count_value;
    end
    if (rd_status)
    begin
      next_rdata[`IRQ_WRAP_BIT] = irq_status;
    end
    if (rd_mask)
    begin
      next_rdata[`IRQ_WRAP_BIT] = irq_mask;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      rdata <= next_rdata;
    end
  end

endmodule

// file: system_tick_timer_bench.sv
// Purpose: Self-checking bench of the tick timer.
// Assumes: Clock enable held high except for three cycles around one count write.
// Notes: Each read queues its expected data for the monitor.
module system_tick_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, clk_en, wr, rd, rd_d;
  logic [7:0] addr;
  logic [31:0] wdata, seed;
  wire [31:0] rdata;
  wire irq;
  logic [31:0] q[$];
  int fails, samples_checked;
  system_tick_timer i_dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  task chk(input [31:0] s, input [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, s, e);
    end
  endtask
  task bus(input w, input r, input [7:0] a, input [31:0] d, input [31:0] e);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    if (r)
      q.push_back(e);
    @(posedge clk);
  endtask
  task stop_test;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (rd_d)
      chk(rdata, q.pop_front());
    rd_d <= rd;
  end
  initial
  begin
    #2000;
    fails++;
    stop_test;
  end
  initial
  begin
    resetn = 0;
    clk_en = 1;
    {wr, rd, rd_d, addr, wdata} = 0;
    seed = $urandom(32'h0AB2);
    repeat (2) @(posedge clk);
    resetn <= 1;
    bus(1, 0, 8'h04, 32'h14, 0);
    bus(0, 1, 8'h04, 0, 32'h14);
    bus(1, 0, 8'h08, $urandom, 0);
    bus(0, 1, 8'h08, 0, 0);
    bus(1, 0, 8'h10, 1, 0);
    repeat (5) bus(0, 0, 0, 0, 0);
    bus(0, 1, 8'h08, 0, 0);
    bus(0, 1, 8'h00, 0, 0);
    bus(1, 0, 8'h00, 1, 0);
    repeat (28) bus(0, 0, 0, 0, 0);
    #1 chk({31'h0, irq}, 1);
    bus(0, 1, 8'h00, 0, 32'h10001);
    bus(0, 1, 8'h00, 0, 1);
    bus(0, 1, 8'h0C, 0, 1);
    bus(1, 0, 8'h0C, 1, 0);
    bus(0, 1, 8'h0C, 0, 0);
    bus(0, 1, 8'h14, 0, 0);
    clk_en <= 0;
    bus(1, 0, 8'h08, 0, 0);
    repeat (2) bus(0, 0, 0, 0, 0);
    clk_en <= 1;
    bus(0, 1, 8'h08, 0, 8);
    bus(1, 0, 8'h04, 0, 0);
    bus(1, 0, 8'h08, 0, 0);
    repeat (5) bus(0, 0, 0, 0, 0);
    bus(0, 1, 8'h08, 0, 0);
    bus(0, 1, 8'h00, 0, 1);
    bus(1, 0, 8'h10, 0, 0);
    repeat (2) bus(0, 0, 0, 0, 0);
    stop_test;
  end
endmodule

// file: tick_timer_properties.sv
// Purpose: Port-level checks of the tick timer.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Bound to every tick timer instance.
module tick_timer_properties (
  // Watched ports
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire irq
);
  wire go_rd = rd && clk_en;
  wire go_wr = wr && clk_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  idle_zero_a: assert property ($past(clk_en) && !$past(go_rd) |-> rdata == 32'h0)
    else $error("read data not idle");
  unmapped_a: assert property (go_rd && addr == 8'h14 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_bits_a: assert property (go_rd && addr == 8'h00 |=> (rdata & 32'hFFFEFFFE) == 32'h0)
    else $error("control spare bits set");
  stat_bits_a: assert property (go_rd && addr == 8'h0C |=> rdata[31:1] == 31'h0)
    else $error("status spare bits set");
  count_width_a: assert property (go_rd && addr == 8'h08 |=> rdata[31:24] == 8'h00)
    else $error("count wider than 24 bits");
  count_clear_a: assert property (go_wr && addr == 8'h08 ##1 go_rd && addr == 8'h08 |=> rdata == 32'h0)
    else $error("count not cleared");
  reload_back_a: assert property (go_wr && addr == 8'h04 ##1 go_rd && addr == 8'h04
    |=> rdata[23:0] == $past(wdata[23:0], 2)) else $error("reload readback wrong");
  mask_off_a: assert property (go_wr && addr == 8'h10 && !wdata[0] |=> !irq)
    else $error("masked interrupt still high");
  cover property (go_rd && addr == 8'h00 ##1 rdata[16]);
  cover property ($rose(irq));
  cover property (go_wr && addr == 8'h0C && wdata[0]);
endmodule
bind system_tick_timer tick_timer_properties i_props (.clk(clk), .resetn(resetn),
  .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// file: tick_timer_regs.vh
// Purpose: Register offsets, field positions and reset values of the tick timer.
// Assumes: 32-bit register port, byte addresses, one aligned word per register.
// Notes: Definitions only.
`ifndef TICK_TIMER_REGS_VH
`define TICK_TIMER_REGS_VH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_RELOAD 8'h04
`define OFS_CURRENT 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define COUNT_WIDTH 24
`define CTRL_ENABLE_BIT 0
`define CTRL_WRAP_FLAG_BIT 16
`define IRQ_WRAP_BIT 0
`define RELOAD_RESET 24'h000000
`define MASK_RESET 1'h0

`endif
